/* File: mba_regs.svh */
// register offsets, field positions, reset values and status codes
`ifndef MBA_REGS_SVH
`define MBA_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MBA_ADDR_W        4
`define MBA_ADDR_CTRL     4'h0
`define MBA_ADDR_STAT     4'h4
`define MBA_ADDR_CNT      4'h8

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define MBA_CTRL_W        4
`define MBA_CTRL_ANY      0
`define MBA_CTRL_IOB      1
`define MBA_CTRL_RESIDENT_BUS_STRAP     2
`define MBA_CTRL_COMMON_REQUEST_LOCK   3
`define MBA_CTRL_RST      4'h0

// ----------------------------------------------------------------
// status register layout, low bit first
// ----------------------------------------------------------------
`define MBA_STAT_W        8

// ----------------------------------------------------------------
// processor status codes, s2 s1 s0
// ----------------------------------------------------------------
`define MBA_PS_IDLE       3'h7
`define MBA_PS_HALT       3'h3
`define MBA_PS_MEM_BIT    2

`endif

/* File: mba_pkg.sv */
// types shared by the bus arbiter files
package mba_pkg;

  // ----------------------------------------------------------------
  // arbiter states, gray along idle-wait-own-release
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MBA_S_IDLE = 2'h0,
    MBA_S_WAIT = 2'h1,
    MBA_S_OWN  = 2'h3,
    MBA_S_REL  = 2'h2
  } mba_state_type;

endpackage : mba_pkg

/* File: mba_status_decode.sv */
// processor status decoder for the bus arbiter
`timescale 1ns/1ps
`include "mba_regs.svh"

module mba_status_decode (
  input  wire logic [2:0] proc_status,
  output logic            idle_status,
  output logic            halt_status,
  output logic            active_status,
  output logic            mem_cmd,
  output logic            io_cmd
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    idle_status   = (proc_status == `MBA_PS_IDLE);
    halt_status   = (proc_status == `MBA_PS_HALT);
    active_status = !idle_status && !halt_status;
    mem_cmd       = active_status && proc_status[`MBA_PS_MEM_BIT];
    io_cmd        = active_status && !proc_status[`MBA_PS_MEM_BIT];
  end

endmodule : mba_status_decode

/* File: mba_arbiter.sv */
// multi-master system bus arbiter, device side
//
// Operation
// - with bus free and priority in, seize bus and drive busy low
// - when done, stop driving the open-drain busy line
// - gaining priority while bus is busy, wait for busy to go high
// - occupant losing priority gives up bus after its transfer ends
// - all arbitration is clocked by the bus clock
// - without the bus, keep controller, transceivers and latches disabled
// - once bus is held, enable controller so the command completes
// - keep the bus unless halted or forced off by another request
// - any-request strap surrenders to lower priority like to higher
// - higher wins after current transfer; lower only when bus unused
// - serial mode chains priority out into next arbiter's priority in
// - peripheral-bus mode sends io commands locally, memory to system bus
// - resident-bus mode lets bus select decide system or resident bus
// - both straps off means system bus only; both on serves all three
// - single-bus mode requests on any active status but halt or idle
// - idle status is 111, halt status is 011
// - lock blocks any surrender; request lock blocks surrender to lower
// - bus-wide initialise resets arbiter, leaving the bus unheld
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mba_regs.svh"

module mba_arbiter #(
  parameter int DW = 8,
  parameter int CW = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   init_n,
  input  wire logic [2:0]             proc_status,
  input  wire logic                   lock_n,
  input  wire logic                   bus_select_input,
  input  wire logic                   transfer_acknowledge,
  input  wire logic                   priority_in_n,
  input  wire logic                   busy_in,
  input  wire logic                   common_request_in,
  output logic                        bus_request_out_n,
  output logic                        priority_out_n,
  output logic                        busy_out,
  output logic                        busy_oe_n,
  output logic                        common_request_out,
  output logic                        common_request_oe_n,
  output logic                        address_enable_out_n,
  input  wire logic [`MBA_ADDR_W-1:0] reg_addr,
  input  wire logic [DW-1:0]          reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [DW-1:0]          reg_rdata
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DW < `MBA_STAT_W || DW > 32) begin : g_dw_chk
    $error("data width must be 8 to 32");
  end
  if (CW < 1 || CW > DW) begin : g_cw_chk
    $error("counter width must be 1 to data width");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  mba_pkg::mba_state_type state_r;
  mba_pkg::mba_state_type state_nxt;
  logic [`MBA_CTRL_W-1:0] ctrl_r;
  logic [`MBA_CTRL_W-1:0] ctrl_nxt;
  logic [CW-1:0]          cnt_r;
  logic [CW-1:0]          cnt_nxt;
  logic [DW-1:0]          rdata_r;
  logic [DW-1:0]          rdata_nxt;
  logic                   idle_status;
  logic                   halt_status;
  logic                   active_status;
  logic                   mem_cmd;
  logic                   io_cmd;
  logic                   any_request_strap;
  logic                   peripheral_bus_strap;
  logic                   resident_bus_strap;
  logic                   common_request_lock;
  logic                   need_sys;
  logic                   free_sys;
  logic                   boundary;
  logic                   higher_priority_request;
  logic                   lower_request;
  logic                   surrender;
  logic                   own;
  logic [`MBA_STAT_W-1:0] stat_word;

  // ----------------------------------------------------------------
  // status decode
  // ----------------------------------------------------------------
  mba_status_decode u_dec (
    .proc_status   (proc_status),
    .idle_status   (idle_status),
    .halt_status   (halt_status),
    .active_status (active_status),
    .mem_cmd       (mem_cmd),
    .io_cmd        (io_cmd)
  );

  assign any_request_strap    = ctrl_r[`MBA_CTRL_ANY];
  assign peripheral_bus_strap = ctrl_r[`MBA_CTRL_IOB];
  assign resident_bus_strap   = ctrl_r[`MBA_CTRL_RESIDENT_BUS_STRAP];
  assign common_request_lock  = ctrl_r[`MBA_CTRL_COMMON_REQUEST_LOCK];
  assign own                  = (state_r == mba_pkg::MBA_S_OWN);

  // ----------------------------------------------------------------
  // request and surrender conditions
  // ----------------------------------------------------------------
  always_comb begin
    case ({peripheral_bus_strap, resident_bus_strap})
      2'h0: need_sys = active_status;
      2'h1: need_sys = active_status && bus_select_input;
      2'h2: need_sys = mem_cmd;
      2'h3: need_sys = mem_cmd && bus_select_input;
      default: need_sys = 1'b0;
    endcase
    // not using the system bus right now: idle, halt, local access
    free_sys = !need_sys;
    boundary = free_sys || transfer_acknowledge;
    higher_priority_request = priority_in_n;
    lower_request = common_request_in && !common_request_lock;
    surrender = lock_n &&
                (halt_status ||
                 (boundary && higher_priority_request) ||
                 (lower_request &&
                  (free_sys ||
                   (any_request_strap && transfer_acknowledge))));
  end

  // ----------------------------------------------------------------
  // arbitration state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mba_pkg::MBA_S_IDLE: begin
        if (need_sys) begin
          state_nxt = mba_pkg::MBA_S_WAIT;
        end
      end
      mba_pkg::MBA_S_WAIT: begin
        if (!need_sys) begin
          state_nxt = mba_pkg::MBA_S_IDLE;
        end else if (!priority_in_n && busy_in) begin
          state_nxt = mba_pkg::MBA_S_OWN;
        end
      end
      mba_pkg::MBA_S_OWN: begin
        if (surrender) begin
          state_nxt = mba_pkg::MBA_S_REL;
        end
      end
      mba_pkg::MBA_S_REL: begin
        // one cycle off the line lets busy rise for the next winner
        state_nxt = mba_pkg::MBA_S_IDLE;
      end
      default: state_nxt = mba_pkg::MBA_S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !init_n) begin
      state_r <= mba_pkg::MBA_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign busy_out             = 1'b0;
  assign busy_oe_n            = !own;
  assign address_enable_out_n = !own;
  assign bus_request_out_n    = !(state_r == mba_pkg::MBA_S_WAIT || own);
  assign common_request_out   = 1'b0;
  assign common_request_oe_n  = !(state_r == mba_pkg::MBA_S_WAIT);
  assign priority_out_n       = !(!priority_in_n && !need_sys &&
                                  state_r == mba_pkg::MBA_S_IDLE);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign stat_word = {1'b0, state_r, common_request_in, !priority_in_n,
                      busy_in, state_r == mba_pkg::MBA_S_WAIT, own};

  always_comb begin
    ctrl_nxt  = ctrl_r;
    cnt_nxt   = cnt_r;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == `MBA_ADDR_CTRL) begin
      ctrl_nxt = reg_wdata[`MBA_CTRL_W-1:0];
    end
    if (reg_wr && reg_addr == `MBA_ADDR_CNT) begin
      cnt_nxt = '0;
    end else if (state_r == mba_pkg::MBA_S_WAIT &&
                 state_nxt == mba_pkg::MBA_S_OWN) begin
      cnt_nxt = CW'(cnt_r + 1'b1);
    end
    if (reg_rd) begin
      case (reg_addr)
        `MBA_ADDR_CTRL: rdata_nxt = DW'(ctrl_r);
        `MBA_ADDR_STAT: rdata_nxt = DW'(stat_word);
        `MBA_ADDR_CNT:  rdata_nxt = DW'(cnt_r);
        default:        rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r  <= `MBA_CTRL_RST;
      cnt_r   <= '0;
      rdata_r <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !init_n);

  seize_on_free_a: assert property (
    $rose(own) |-> $past(!priority_in_n) && $past(busy_in) && !busy_oe_n)
    else $error("bus taken without priority or while busy");

  release_busy_a: assert property (
    (own && surrender) |=> busy_oe_n ##1 (state_r == mba_pkg::MBA_S_IDLE))
    else $error("busy still driven after surrender");

  wait_busy_a: assert property (
    (state_r == mba_pkg::MBA_S_WAIT && !busy_in) |=> !own)
    else $error("bus seized while busy was low");

  lost_priority_a: assert property (
    (own && priority_in_n && lock_n && !need_sys) |=> !own)
    else $error("occupant kept bus after losing priority");

  disabled_off_a: assert property (
    !own |-> address_enable_out_n && busy_oe_n)
    else $error("bus drivers enabled without ownership");

  enable_on_a: assert property (
    (state_r == mba_pkg::MBA_S_WAIT && need_sys && !priority_in_n &&
     busy_in) |=> !address_enable_out_n)
    else $error("drivers not enabled on acquisition");

  keep_bus_a: assert property (
    (own && !halt_status && !priority_in_n && !common_request_in)
    |=> own)
    else $error("bus given up with no request and no halt");

  any_request_a: assert property (
    (own && lock_n && any_request_strap && common_request_in &&
     !common_request_lock && transfer_acknowledge) |=> !own)
    else $error("any-request surrender missed");

  io_local_a: assert property (
    (peripheral_bus_strap && io_cmd && state_r == mba_pkg::MBA_S_IDLE)
    |=> state_r != mba_pkg::MBA_S_WAIT)
    else $error("io command requested the system bus");

  lock_hold_a: assert property (
    (own && !lock_n) |=> own)
    else $error("bus surrendered under lock");

  init_free_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !init_n |=> state_r == mba_pkg::MBA_S_IDLE && busy_oe_n)
    else $error("arbiter holds bus after initialise");

  prio_pass_a: assert property (
    !priority_out_n |-> !priority_in_n && !own && !need_sys)
    else $error("priority passed while requesting or owning");

  cover_acquire_c: cover property (
    state_r == mba_pkg::MBA_S_WAIT ##1 own);
  cover_blocked_c: cover property (
    (state_r == mba_pkg::MBA_S_WAIT && !busy_in) [*3] ##1 own);
  cover_preempt_c: cover property (
    own && priority_in_n && transfer_acknowledge ##1
    state_r == mba_pkg::MBA_S_REL);
  cover_halt_c: cover property (own && halt_status ##2 !own);

endmodule : mba_arbiter

/* File: mba_peer_model.sv */
// higher-priority peer arbiter and parallel priority logic for the bench
`timescale 1ns/1ps

module mba_peer_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic hi_req,
  input  wire logic lo_req,
  input  wire logic busy_oe_n,
  output logic      priority_in_n,
  output logic      busy_in,
  output logic      common_request_in,
  output logic      peer_own
);
  // ----------------------------------------------------------------
  // peer seizes the bus only on a clock edge while the line is free
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !hi_req) begin
      peer_own <= 1'b0;
    end else if (busy_in) begin
      peer_own <= 1'b1;
    end
  end

  // shared busy line has a pull-up and reads high when nobody pulls it
  assign busy_in           = busy_oe_n && !peer_own;
  // grant is a single gate level, settling well inside one bus clock
  assign priority_in_n     = hi_req;
  assign common_request_in = lo_req;
endmodule : mba_peer_model

/* File: tb.sv */
// self-checking bench for the system bus arbiter
`timescale 1ns/1ps
`include "mba_regs.svh"

module tb;
  typedef struct packed {
    logic [3:0] c;
    logic [2:0] s;
    logic       b;
    logic       e;
  } mba_row_type;

  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       init_n = 1'b1;
  logic [2:0] proc_status = 3'h7;
  logic       lock_n = 1'b1;
  logic       bus_select_input = 1'b0;
  logic       transfer_acknowledge = 1'b0;
  logic       hi_req = 1'b0;
  logic       lo_req = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       priority_in_n, busy_in, common_request_in, peer_own;
  logic       bus_request_out_n, priority_out_n, busy_out, busy_oe_n;
  logic       common_request_out, common_request_oe_n;
  logic       address_enable_out_n;
  int         fail_count = 0;
  int         comparisons = 0;
  int         acq = 0;
  mba_row_type rows [0:10] = '{
    '{4'h0, 3'h4, 1'h0, 1'h1}, '{4'h0, 3'h0, 1'h0, 1'h1},
    '{4'h0, 3'h3, 1'h0, 1'h0}, '{4'h0, 3'h7, 1'h0, 1'h0},
    '{4'h2, 3'h1, 1'h0, 1'h0}, '{4'h2, 3'h5, 1'h0, 1'h1},
    '{4'h4, 3'h2, 1'h1, 1'h1}, '{4'h4, 3'h6, 1'h0, 1'h0},
    '{4'h6, 3'h4, 1'h1, 1'h1}, '{4'h6, 3'h4, 1'h0, 1'h0},
    '{4'h6, 3'h0, 1'h1, 1'h0}};

  always #4 sys_clk = ~sys_clk;

  mba_arbiter i_dut (.sys_clk, .rst_n, .init_n, .proc_status, .lock_n,
    .bus_select_input, .transfer_acknowledge, .priority_in_n, .busy_in,
    .common_request_in, .bus_request_out_n, .priority_out_n, .busy_out,
    .busy_oe_n, .common_request_out, .common_request_oe_n,
    .address_enable_out_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  mba_peer_model i_peer (.sys_clk, .rst_n, .hi_req, .lo_req, .busy_oe_n,
    .priority_in_n, .busy_in, .common_request_in, .peer_own);

  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_byte("reg_rdata", e, reg_rdata);
  endtask : rd

  task automatic ack;
    @(posedge sys_clk);
    transfer_acknowledge <= 1'b1;
    @(posedge sys_clk);
    transfer_acknowledge <= 1'b0;
  endtask : ack

  task automatic wt_aen(input logic v);
    int n;
    n = 0;
    #1;
    while (address_enable_out_n !== v && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_bit("address_enable_out_n", v, address_enable_out_n);
    if (address_enable_out_n !== v) begin
      finish_test;
    end
  endtask : wt_aen

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk_bit("address_enable_out_n", 1'b1, address_enable_out_n);
    chk_bit("busy_oe_n", 1'b1, busy_oe_n);
    rd(`MBA_ADDR_CTRL, 8'h00);
    rd(`MBA_ADDR_CNT, 8'h00);
    rd(4'hC, 8'h00);
    $display("test reset done");
    // ----------------------------------------------------------------
    // mode decode rows: init, set straps, apply status, check grant
    // ----------------------------------------------------------------
    foreach (rows[i]) begin
      @(posedge sys_clk);
      init_n <= 1'b0;
      proc_status <= 3'h7;
      wr(`MBA_ADDR_CTRL, {4'h0, rows[i].c});
      init_n <= 1'b1;
      proc_status <= rows[i].s;
      bus_select_input <= rows[i].b;
      idle(4);
      if (rows[i].e) acq++;
      chk_bit("bus_request_out_n", !rows[i].e, bus_request_out_n);
      chk_bit("address_enable_out_n", !rows[i].e, address_enable_out_n);
      chk_bit("busy_oe_n", !rows[i].e, busy_oe_n);
    end
    rd(`MBA_ADDR_CNT, acq[7:0]);
    wr(`MBA_ADDR_CNT, 8'h00);
    rd(`MBA_ADDR_CNT, 8'h00);
    wr(`MBA_ADDR_CTRL, 8'hFF);
    rd(`MBA_ADDR_CTRL, 8'h0F);
    $display("test rows done");
    // ----------------------------------------------------------------
    // higher peer holds the bus, then hands over and takes it back
    // ----------------------------------------------------------------
    @(posedge sys_clk);
    init_n <= 1'b0;
    hi_req <= 1'b1;
    wr(`MBA_ADDR_CTRL, 8'h00);
    init_n <= 1'b1;
    proc_status <= 3'h4;
    idle(4);
    chk_bit("peer_own", 1'b1, peer_own);
    chk_bit("bus_request_out_n", 1'b0, bus_request_out_n);
    chk_bit("address_enable_out_n", 1'b1, address_enable_out_n);
    chk_bit("common_request_oe_n", 1'b0, common_request_oe_n);
    chk_bit("common_request_out", 1'b0, common_request_out);
    chk_bit("busy_out", 1'b0, busy_out);
    hi_req <= 1'b0;
    wt_aen(1'b0);
    chk_bit("common_request_oe_n", 1'b1, common_request_oe_n);
    rd(`MBA_ADDR_STAT, {1'b0, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1});
    hi_req <= 1'b1;
    idle(3);
    chk_bit("address_enable_out_n", 1'b0, address_enable_out_n);
    ack;
    wt_aen(1'b1);
    chk_bit("busy_oe_n", 1'b1, busy_oe_n);
    idle(4);
    chk_bit("peer_own", 1'b1, peer_own);
    $display("test handover done");
    // ----------------------------------------------------------------
    // lock holds the bus against a higher request
    // ----------------------------------------------------------------
    hi_req <= 1'b0;
    wt_aen(1'b0);
    lock_n <= 1'b0;
    hi_req <= 1'b1;
    ack;
    idle(4);
    chk_bit("address_enable_out_n", 1'b0, address_enable_out_n);
    lock_n <= 1'b1;
    ack;
    wt_aen(1'b1);
    hi_req <= 1'b0;
    $display("test lock done");
    // ----------------------------------------------------------------
    // lower requester: kept off, then served with the any strap
    // ----------------------------------------------------------------
    wt_aen(1'b0);
    lo_req <= 1'b1;
    ack;
    idle(4);
    chk_bit("address_enable_out_n", 1'b0, address_enable_out_n);
    wr(`MBA_ADDR_CTRL, 8'h09);
    ack;
    idle(2);
    chk_bit("address_enable_out_n", 1'b0, address_enable_out_n);
    wr(`MBA_ADDR_CTRL, 8'h01);
    ack;
    wt_aen(1'b1);
    lo_req <= 1'b0;
    wt_aen(1'b0);
    wr(`MBA_ADDR_CTRL, 8'h00);
    proc_status <= `MBA_PS_HALT;
    wt_aen(1'b1);
    $display("test surrender done");
    // ----------------------------------------------------------------
    // priority passes down only while idle
    // ----------------------------------------------------------------
    proc_status <= `MBA_PS_IDLE;
    idle(3);
    chk_bit("priority_out_n", 1'b0, priority_out_n);
    proc_status <= 3'h4;
    wt_aen(1'b0);
    chk_bit("priority_out_n", 1'b1, priority_out_n);
    $display("test chain done");
    finish_test;
  end
endmodule : tb
